// ==== logic/sfcd_defines.svh ====
// constants of the serial flash command decoder
`ifndef SFCD_DEFINES_SVH
`define SFCD_DEFINES_SVH
// ----------------------------------------
// opcodes
// ----------------------------------------
`define SFCD_OP_WREN 8'h06
`define SFCD_OP_WRDI 8'h04
`define SFCD_OP_RDSR1 8'h05
`define SFCD_OP_RDSR2 8'h35
`define SFCD_OP_WRSR 8'h01
`define SFCD_OP_PP 8'h02
`define SFCD_OP_QPP 8'h32
`define SFCD_OP_SE 8'h20
`define SFCD_OP_BE32 8'h52
`define SFCD_OP_BE64 8'hd8
`define SFCD_OP_CE1 8'hc7
`define SFCD_OP_CE2 8'h60
`define SFCD_OP_PD 8'hb9
`define SFCD_OP_RPD 8'hab
`define SFCD_OP_MID 8'h90
`define SFCD_OP_MID2 8'hef
`define SFCD_OP_MID4 8'hdf
`define SFCD_OP_JID 8'h9f
// ----------------------------------------
// status fields and reset value
// ----------------------------------------
`define SFCD_ST_BUSY 0
`define SFCD_ST_WPL 1
`define SFCD_ST_BP0 2
`define SFCD_ST_BP1 3
`define SFCD_ST_BP2 4
`define SFCD_ST_BOTTOM 5
`define SFCD_ST_GRAN 6
`define SFCD_ST_WMASK_LO 8'hfc
`define SFCD_ST_WMASK_HI 8'h03
`define SFCD_STATUS_RST 16'h0000
// ----------------------------------------
// transfer counts
// ----------------------------------------
`define SFCD_ADDR_LAST 3'd2
`define SFCD_BYTE_MAX 3'd7
`endif

// ==== logic/sfcd_pkg.sv ====
// types of the serial flash command decoder
package sfcd_pkg;
    typedef enum logic [2:0] {
        SFCD_PH_IDLE, SFCD_PH_OPCODE, SFCD_PH_ADDR, SFCD_PH_DATA, SFCD_PH_OUT, SFCD_PH_SKIP
    } sfcd_phase_t;

    typedef enum logic [3:0] {
        SFCD_CMD_NONE, SFCD_CMD_WREN, SFCD_CMD_WRDI, SFCD_CMD_RDSR1, SFCD_CMD_RDSR2,
        SFCD_CMD_WRSR, SFCD_CMD_PP, SFCD_CMD_QPP, SFCD_CMD_SE, SFCD_CMD_BE32,
        SFCD_CMD_BE64, SFCD_CMD_CE, SFCD_CMD_PD, SFCD_CMD_RPD, SFCD_CMD_MID, SFCD_CMD_JID
    } sfcd_cmd_t;

    typedef struct packed {
        logic [2:0] sclk_sync;
        logic [2:0] sel_n_sync;
        logic [3:0] lane_s1;
        logic [3:0] lane_s2;
        sfcd_phase_t phase;
        sfcd_cmd_t cmd;
        logic [2:0] lane_cnt;
        logic [2:0] bit_cnt;
        logic [2:0] byte_cnt;
        logic [7:0] in_sh;
        logic [23:0] addr;
        logic [7:0] out_sh;
        logic [1:0] id_idx;
        logic id_swap;
        logic data_seen;
        logic [15:0] status;
        logic [15:0] wr_status;
        logic power_down;
        logic [3:0] lane_drive;
        logic [3:0] lane_en;
        logic wr_valid;
        logic [7:0] wr_byte;
        logic op_start;
        sfcd_cmd_t op_kind;
        logic [23:0] op_addr;
    } sfcd_state_t;
endpackage

// ==== logic/sfcd_prot_if.sv ====
// protection bits and the protected range between decoder and mapper
interface sfcd_prot_if;
    logic granularity_select_bit;
    logic bottom_origin_bit;
    logic protect_size_bit2;
    logic protect_size_bit1;
    logic protect_size_bit0;
    logic [23:0] prot_lo;
    logic [23:0] prot_hi;
    logic prot_any;
    modport mapper (
        input granularity_select_bit, bottom_origin_bit, protect_size_bit2, protect_size_bit1,
        protect_size_bit0,
        output prot_lo, prot_hi, prot_any
    );
    modport user (
        output granularity_select_bit, bottom_origin_bit, protect_size_bit2, protect_size_bit1,
        protect_size_bit0,
        input prot_lo, prot_hi, prot_any
    );
endinterface

// ==== logic/sfcd_protect.sv ====
// maps the protect bits of the status register to a protected address range
module sfcd_protect #(
    parameter int ARRAY_BITS = 20
) (
    sfcd_prot_if.mapper pif
);
    import sfcd_pkg::*;

    if (ARRAY_BITS < 16 || ARRAY_BITS > 24) begin : g_bad_size
        $error("sfcd_protect: ARRAY_BITS must lie in 16..24");
    end

    localparam logic [24:0] TOP = 25'((25'h1 << ARRAY_BITS) - 25'h1);

    logic [2:0] code;
    logic [4:0] sz_log;
    logic [24:0] mask;

    always_comb begin
        code = {pif.protect_size_bit2, pif.protect_size_bit1, pif.protect_size_bit0};
        sz_log = 5'(ARRAY_BITS);
        pif.prot_any = 1'b1;
        if (code == 3'h0) begin
            pif.prot_any = 1'b0;
        end else if (code[2] && code[1]) begin
            sz_log = 5'(ARRAY_BITS);
        end else if (!pif.granularity_select_bit) begin
            sz_log = 5'(ARRAY_BITS - 5) + 5'(code);
        end else begin
            sz_log = 5'(ARRAY_BITS - 9) + 5'((code > 3'h4) ? 3'h4 : code);
        end
        mask = 25'((25'h1 << sz_log) - 25'h1);
        if (pif.bottom_origin_bit || sz_log == 5'(ARRAY_BITS)) begin
            pif.prot_lo = 24'h00_0000;
            pif.prot_hi = mask[23:0];
        end else begin
            pif.prot_lo = 24'(TOP - mask);
            pif.prot_hi = TOP[23:0];
        end
    end
endmodule

// ==== logic/sfcd_decoder.sv ====
// instruction decoder of the serial flash interface, sampled on the core clock
// ----------------------------------------
// ----------------------------------------
`include "sfcd_defines.svh"

module sfcd_decoder #(
    parameter logic [7:0] MFR_ID = 8'h5a,    // arbitrary value
    parameter logic [7:0] DEV_ID = 8'h21,    // arbitrary value
    parameter logic [7:0] MEM_TYPE = 8'h40,  // arbitrary value
    parameter logic [7:0] CAPACITY = 8'h14,  // arbitrary value
    parameter int ARRAY_BITS = 20
) (
    input wire logic core_clk_in,
    input wire logic rst_in,
    input wire logic sclk_in,
    input wire logic sel_n_in,
    input wire logic [3:0] lanes_in,
    output logic [3:0] lanes_out,
    output logic [3:0] lanes_oe_out,
    input wire logic op_done_in,
    output logic op_start_out,
    output sfcd_pkg::sfcd_cmd_t op_kind_out,
    output logic [23:0] op_addr_out,
    output logic wr_valid_out,
    output logic [7:0] wr_byte_out,
    output logic [15:0] status_out,
    output logic powered_down_out,
    output logic [23:0] prot_lo_out,
    output logic [23:0] prot_hi_out,
    output logic prot_any_out
);
    import sfcd_pkg::*;

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    function automatic logic [7:0] shift_in(input logic [7:0] sh, input logic [3:0] ln, input logic [2:0] cnt);
        case (cnt)
            3'd4: return {sh[3:0], ln};
            3'd2: return {sh[5:0], ln[1:0]};
            default: return {sh[6:0], ln[0]};
        endcase
    endfunction

    function automatic logic [2:0] last_bit(input logic [2:0] cnt);
        case (cnt)
            3'd4: return 3'd1;
            3'd2: return 3'd3;
            default: return 3'd7;
        endcase
    endfunction

    function automatic sfcd_cmd_t decode(input logic [7:0] op);
        case (op)
            `SFCD_OP_WREN: return SFCD_CMD_WREN;
            `SFCD_OP_WRDI: return SFCD_CMD_WRDI;
            `SFCD_OP_RDSR1: return SFCD_CMD_RDSR1;
            `SFCD_OP_RDSR2: return SFCD_CMD_RDSR2;
            `SFCD_OP_WRSR: return SFCD_CMD_WRSR;
            `SFCD_OP_PP: return SFCD_CMD_PP;
            `SFCD_OP_QPP: return SFCD_CMD_QPP;
            `SFCD_OP_SE: return SFCD_CMD_SE;
            `SFCD_OP_BE32: return SFCD_CMD_BE32;
            `SFCD_OP_BE64: return SFCD_CMD_BE64;
            `SFCD_OP_CE1, `SFCD_OP_CE2: return SFCD_CMD_CE;
            `SFCD_OP_PD: return SFCD_CMD_PD;
            `SFCD_OP_RPD: return SFCD_CMD_RPD;
            `SFCD_OP_MID, `SFCD_OP_MID2, `SFCD_OP_MID4: return SFCD_CMD_MID;
            `SFCD_OP_JID: return SFCD_CMD_JID;
            default: return SFCD_CMD_NONE;
        endcase
    endfunction

    function automatic logic [7:0] jid_byte(input logic [1:0] idx);
        case (idx)
            2'd1: return MEM_TYPE;
            2'd2: return CAPACITY;
            default: return MFR_ID;
        endcase
    endfunction

    // ----------------------------------------
    // protection mapper
    // ----------------------------------------
    sfcd_state_t s_ff;
    sfcd_state_t nxt_s;
    sfcd_prot_if pif ();

    assign pif.granularity_select_bit = s_ff.status[`SFCD_ST_GRAN];
    assign pif.bottom_origin_bit = s_ff.status[`SFCD_ST_BOTTOM];
    assign pif.protect_size_bit2 = s_ff.status[`SFCD_ST_BP2];
    assign pif.protect_size_bit1 = s_ff.status[`SFCD_ST_BP1];
    assign pif.protect_size_bit0 = s_ff.status[`SFCD_ST_BP0];

    sfcd_protect #(
        .ARRAY_BITS(ARRAY_BITS)
    ) u_protect (
        .pif(pif)
    );

    // ----------------------------------------
    // next state
    // ----------------------------------------
    logic sclk_rise;
    logic sel_fall;
    logic sel_rise;
    logic last;
    logic aligned;
    logic busy;
    logic wpl;
    logic addr_hit;
    logic [7:0] sh;
    sfcd_cmd_t dc;

    always_comb begin
        nxt_s = s_ff;
        sh = shift_in(s_ff.in_sh, s_ff.lane_s2, s_ff.lane_cnt);
        dc = decode(sh);
        last = s_ff.bit_cnt == last_bit(s_ff.lane_cnt);
        aligned = s_ff.bit_cnt == 3'd0;
        busy = s_ff.status[`SFCD_ST_BUSY];
        wpl = s_ff.status[`SFCD_ST_WPL];
        addr_hit = pif.prot_any && s_ff.addr >= pif.prot_lo && s_ff.addr <= pif.prot_hi;
        sclk_rise = s_ff.sclk_sync[1] && !s_ff.sclk_sync[2];
        sel_fall = !s_ff.sel_n_sync[1] && s_ff.sel_n_sync[2];
        sel_rise = s_ff.sel_n_sync[1] && !s_ff.sel_n_sync[2];

        nxt_s.sclk_sync = {s_ff.sclk_sync[1:0], sclk_in};
        nxt_s.sel_n_sync = {s_ff.sel_n_sync[1:0], sel_n_in};
        nxt_s.lane_s1 = lanes_in;
        nxt_s.lane_s2 = s_ff.lane_s1;
        nxt_s.wr_valid = 1'b0;
        nxt_s.op_start = 1'b0;

        if (busy && op_done_in) begin
            nxt_s.status[`SFCD_ST_BUSY] = 1'b0;
            nxt_s.status[`SFCD_ST_WPL] = 1'b0;
        end

        if (sel_fall) begin
            nxt_s.phase = SFCD_PH_OPCODE;
            nxt_s.cmd = SFCD_CMD_NONE;
            nxt_s.lane_cnt = 3'd1;
            nxt_s.bit_cnt = 3'd0;
            nxt_s.byte_cnt = 3'd0;
            nxt_s.data_seen = 1'b0;
        end else if (sel_rise) begin
            nxt_s.phase = SFCD_PH_IDLE;
            if (s_ff.cmd == SFCD_CMD_RPD && s_ff.phase != SFCD_PH_SKIP) begin
                nxt_s.power_down = 1'b0;
            end
            if (s_ff.phase == SFCD_PH_DATA && aligned) begin
                case (s_ff.cmd)
                    SFCD_CMD_WREN: nxt_s.status[`SFCD_ST_WPL] = 1'b1;
                    SFCD_CMD_WRDI: nxt_s.status[`SFCD_ST_WPL] = 1'b0;
                    SFCD_CMD_PD: nxt_s.power_down = 1'b1;
                    SFCD_CMD_WRSR: begin
                        if (wpl && (s_ff.byte_cnt == 3'd1 || s_ff.byte_cnt == 3'd2)) begin
                            nxt_s.status[7:0] = (s_ff.status[7:0] & ~`SFCD_ST_WMASK_LO)
                                | (s_ff.wr_status[7:0] & `SFCD_ST_WMASK_LO);
                            nxt_s.status[15:8] = (s_ff.status[15:8] & ~`SFCD_ST_WMASK_HI)
                                | ((s_ff.byte_cnt == 3'd2 ? s_ff.wr_status[15:8] : 8'h00) & `SFCD_ST_WMASK_HI);
                            nxt_s.status[`SFCD_ST_BUSY] = 1'b1;
                            nxt_s.op_start = 1'b1;
                        end
                    end
                    SFCD_CMD_PP, SFCD_CMD_QPP: begin
                        if (wpl && s_ff.data_seen && !addr_hit) begin
                            nxt_s.status[`SFCD_ST_BUSY] = 1'b1;
                            nxt_s.op_start = 1'b1;
                        end
                    end
                    SFCD_CMD_SE, SFCD_CMD_BE32, SFCD_CMD_BE64: begin
                        if (wpl && !addr_hit) begin
                            nxt_s.status[`SFCD_ST_BUSY] = 1'b1;
                            nxt_s.op_start = 1'b1;
                        end
                    end
                    SFCD_CMD_CE: begin
                        if (wpl && !pif.prot_any) begin
                            nxt_s.status[`SFCD_ST_BUSY] = 1'b1;
                            nxt_s.op_start = 1'b1;
                        end
                    end
                    default: begin
                    end
                endcase
                nxt_s.op_kind = s_ff.cmd;
                nxt_s.op_addr = s_ff.addr;
            end
        end else if (sclk_rise && s_ff.phase != SFCD_PH_IDLE && s_ff.phase != SFCD_PH_SKIP) begin
            nxt_s.in_sh = sh;
            nxt_s.bit_cnt = last ? 3'd0 : s_ff.bit_cnt + 3'd1;
            case (s_ff.phase)
                SFCD_PH_OUT: begin
                    nxt_s.out_sh = s_ff.out_sh << s_ff.lane_cnt;
                    if (last) begin
                        case (s_ff.cmd)
                            SFCD_CMD_RDSR1: nxt_s.out_sh = s_ff.status[7:0];
                            SFCD_CMD_RDSR2: nxt_s.out_sh = s_ff.status[15:8];
                            SFCD_CMD_RPD: nxt_s.out_sh = DEV_ID;
                            SFCD_CMD_MID: begin
                                nxt_s.id_swap = !s_ff.id_swap;
                                nxt_s.out_sh = s_ff.id_swap ? MFR_ID : DEV_ID;
                            end
                            default: begin
                                nxt_s.id_idx = (s_ff.id_idx == 2'd2) ? 2'd0 : s_ff.id_idx + 2'd1;
                                nxt_s.out_sh = jid_byte(s_ff.id_idx);
                            end
                        endcase
                    end
                end
                SFCD_PH_OPCODE: begin
                    if (last) begin
                        nxt_s.cmd = dc;
                        nxt_s.phase = SFCD_PH_ADDR;
                        if (dc == SFCD_CMD_NONE || (busy && dc != SFCD_CMD_RDSR1 && dc != SFCD_CMD_RDSR2)
                            || (s_ff.power_down && dc != SFCD_CMD_RPD)) begin
                            nxt_s.phase = SFCD_PH_SKIP;
                        end else begin
                            case (dc)
                                SFCD_CMD_RDSR1: begin
                                    nxt_s.phase = SFCD_PH_OUT;
                                    nxt_s.out_sh = s_ff.status[7:0];
                                end
                                SFCD_CMD_RDSR2: begin
                                    nxt_s.phase = SFCD_PH_OUT;
                                    nxt_s.out_sh = s_ff.status[15:8];
                                end
                                SFCD_CMD_JID: begin
                                    nxt_s.phase = SFCD_PH_OUT;
                                    nxt_s.out_sh = MFR_ID;
                                    nxt_s.id_idx = 2'd1;
                                end
                                SFCD_CMD_WREN, SFCD_CMD_WRDI, SFCD_CMD_WRSR, SFCD_CMD_CE, SFCD_CMD_PD: begin
                                    nxt_s.phase = SFCD_PH_DATA;
                                end
                                SFCD_CMD_MID: begin
                                    nxt_s.lane_cnt = (sh == `SFCD_OP_MID4) ? 3'd4
                                        : (sh == `SFCD_OP_MID2) ? 3'd2 : 3'd1;
                                end
                                default: begin
                                end
                            endcase
                        end
                    end
                end
                SFCD_PH_ADDR: begin
                    if (last) begin
                        nxt_s.addr = {s_ff.addr[15:0], sh};
                        nxt_s.byte_cnt = s_ff.byte_cnt + 3'd1;
                        if (s_ff.byte_cnt == `SFCD_ADDR_LAST) begin
                            nxt_s.byte_cnt = 3'd0;
                            nxt_s.phase = SFCD_PH_DATA;
                            if (s_ff.cmd == SFCD_CMD_QPP) begin
                                nxt_s.lane_cnt = 3'd4;
                            end
                            if (s_ff.cmd == SFCD_CMD_RPD) begin
                                nxt_s.phase = SFCD_PH_OUT;
                                nxt_s.out_sh = DEV_ID;
                            end
                            if (s_ff.cmd == SFCD_CMD_MID) begin
                                nxt_s.phase = SFCD_PH_OUT;
                                nxt_s.id_swap = sh[0];
                                nxt_s.out_sh = sh[0] ? DEV_ID : MFR_ID;
                            end
                        end
                    end
                end
                default: begin
                    if (last) begin
                        if (s_ff.byte_cnt != `SFCD_BYTE_MAX) begin
                            nxt_s.byte_cnt = s_ff.byte_cnt + 3'd1;
                        end
                        if (s_ff.cmd == SFCD_CMD_WRSR && s_ff.byte_cnt == 3'd0) begin
                            nxt_s.wr_status[7:0] = sh;
                        end
                        if (s_ff.cmd == SFCD_CMD_WRSR && s_ff.byte_cnt == 3'd1) begin
                            nxt_s.wr_status[15:8] = sh;
                        end
                        if (s_ff.cmd == SFCD_CMD_PP || s_ff.cmd == SFCD_CMD_QPP) begin
                            nxt_s.wr_valid = 1'b1;
                            nxt_s.wr_byte = sh;
                            nxt_s.data_seen = 1'b1;
                        end
                    end
                end
            endcase
        end

        // lane drive follows the output shifter one lane group at a time
        case (nxt_s.lane_cnt)
            3'd4: nxt_s.lane_drive = nxt_s.out_sh[7:4];
            3'd2: nxt_s.lane_drive = {2'b00, nxt_s.out_sh[7:6]};
            default: nxt_s.lane_drive = {2'b00, nxt_s.out_sh[7], 1'b0};
        endcase
        if (nxt_s.phase != SFCD_PH_OUT) begin
            nxt_s.lane_en = 4'h0;
        end else if (nxt_s.lane_cnt == 3'd4) begin
            nxt_s.lane_en = 4'hf;
        end else if (nxt_s.lane_cnt == 3'd2) begin
            nxt_s.lane_en = 4'h3;
        end else begin
            nxt_s.lane_en = 4'h2;
        end
    end

    // ----------------------------------------
    // state register
    // ----------------------------------------
    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            s_ff <= '0;
            s_ff.sclk_sync <= 3'h0;
            s_ff.sel_n_sync <= 3'h7;
            s_ff.lane_cnt <= 3'd1;
            s_ff.status <= `SFCD_STATUS_RST;
        end else begin
            s_ff <= nxt_s;
        end
    end

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    assign lanes_out = s_ff.lane_drive;
    assign lanes_oe_out = s_ff.lane_en;
    assign op_start_out = s_ff.op_start;
    assign op_kind_out = s_ff.op_kind;
    assign op_addr_out = s_ff.op_addr;
    assign wr_valid_out = s_ff.wr_valid;
    assign wr_byte_out = s_ff.wr_byte;
    assign status_out = s_ff.status;
    assign powered_down_out = s_ff.power_down;
    assign prot_lo_out = pif.prot_lo;
    assign prot_hi_out = pif.prot_hi;
    assign prot_any_out = pif.prot_any;
endmodule

// ==== tb/sfcd_properties.sv ====
// concurrent checks on the command decoder ports
module sfcd_properties (
    input wire logic core_clk_in,
    input wire logic rst_in,
    input wire logic sel_n_in,
    input wire logic op_done_in,
    input wire logic op_start_out,
    input wire logic wr_valid_out,
    input wire logic [3:0] lanes_oe_out,
    input wire logic [15:0] status_out,
    input wire logic [23:0] prot_lo_out,
    input wire logic [23:0] prot_hi_out,
    input wire logic prot_any_out
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge core_clk_in); endclocking
    default disable iff (rst_in);
    sequence s_done; status_out[0] && op_done_in && !op_start_out; endsequence
    sequence s_idle; sel_n_in [*8]; endsequence
    property p_start; op_start_out |-> status_out[0] && $past(sel_n_in) ##1 !op_start_out; endproperty
    a_start: assert property (p_start) else $error("bad start");
    property p_done; s_done |=> status_out[1:0] == 2'b00; endproperty
    a_done: assert property (p_done) else $error("busy kept");
    property p_busy; status_out[0] && !op_done_in |=> status_out[0] && !$rose(status_out[1]); endproperty
    a_busy: assert property (p_busy) else $error("busy broken");
    property p_wr; wr_valid_out |=> !wr_valid_out; endproperty
    a_wr: assert property (p_wr) else $error("data pulse");
    property p_none; status_out[4:2] == 3'b000 |-> !prot_any_out; endproperty
    a_none: assert property (p_none) else $error("range set");
    property p_all;
        status_out[4:3] == 2'b11 |-> prot_any_out && prot_lo_out == 24'h00_0000 && prot_hi_out == 24'h0f_ffff;
    endproperty
    a_all: assert property (p_all) else $error("not all");
    property p_oe; lanes_oe_out inside {4'h0, 4'h2, 4'h3, 4'hf}; endproperty
    a_oe: assert property (p_oe) else $error("bad enable");
    property p_idle; s_idle |-> lanes_oe_out == 4'h0; endproperty
    a_idle: assert property (p_idle) else $error("driven idle");
endmodule

// ==== tb/sfcd_host.sv ====
// behavioural spi host driving the decoder pins
module sfcd_host (
    input wire logic clk_in,
    input wire logic [3:0] lanes_in,
    output logic sclk_out,
    output logic sel_n_out,
    output logic [3:0] lanes_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [255:0] tx;
    logic [63:0] rx;
    initial begin
        sclk_out = 0;
        sel_n_out = 1;
        lanes_out = 4'h0;
    end
    task automatic run(input int n, input int q);
        int p;
        p = 255;
        @(posedge clk_in) sel_n_out <= 0;
        repeat (3) @(posedge clk_in);
        for (int c = 0; c < n; c++) begin
            lanes_out <= (p < q) ? tx[p-:4] : {~lanes_out[3:1], tx[p]};
            p = p - ((p < q) ? 4 : 1);
            repeat (4) @(posedge clk_in);
            rx <= (p < q) ? {rx[59:0], lanes_in} : {rx[62:0], lanes_in[1]};
            sclk_out <= 1;
            repeat (4) @(posedge clk_in);
            sclk_out <= 0;
        end
        repeat (3) @(posedge clk_in);
        sel_n_out <= 1;
        lanes_out <= ~lanes_out;
        // long enough for the synchronised select rise and its start pulse to settle
        repeat (6) @(posedge clk_in);
    endtask
endmodule

// ==== tb/tb.sv ====
// self-checking bench of the command decoder
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import sfcd_pkg::*;
    logic clk = 0, rst = 1, done = 0, sclk, sel_n, any, pd, ost, wv;
    logic [3:0] hl, lin, lout, loe;
    logic [7:0] wbyte, v, h;
    logic [15:0] st, wb;
    logic [23:0] lo, hi, oa;
    logic [31:0] lf = 32'hc835_64e4;
    logic [7:0] ops [5] = '{8'h20, 8'h52, 8'hd8, 8'hc7, 8'h60};
    sfcd_cmd_t kd, kinds [5] = '{SFCD_CMD_SE, SFCD_CMD_BE32, SFCD_CMD_BE64, SFCD_CMD_CE, SFCD_CMD_CE};
    int mismatches = 0, checked = 0, starts = 0, n0, cyc = 0;
    assign lin = (loe & lout) | (~loe & hl);
    always #25 clk = ~clk;
    sfcd_host i_host (.clk_in(clk), .lanes_in(lout), .sclk_out(sclk), .sel_n_out(sel_n), .lanes_out(hl));
    // id values arbitrary
    sfcd_decoder #(.MFR_ID(8'h3c), .DEV_ID(8'h7e), .MEM_TYPE(8'h21), .CAPACITY(8'h45)) i_dut (.core_clk_in(clk),
        .rst_in(rst), .sclk_in(sclk), .sel_n_in(sel_n), .lanes_in(lin), .lanes_out(lout), .lanes_oe_out(loe),
        .op_done_in(done), .op_start_out(ost), .op_kind_out(kd), .op_addr_out(oa), .wr_valid_out(wv),
        .wr_byte_out(wbyte), .status_out(st), .powered_down_out(pd), .prot_lo_out(lo), .prot_hi_out(hi),
        .prot_any_out(any));
    function automatic logic [31:0] nxt(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction
    function automatic logic [48:0] prot_exp(input logic [7:0] s);
        logic [23:0] sz;
        if (s[4:2] == 3'b000) return 0;
        sz = (s[4:3] == 2'b11 || {s[6], s[4:2]} == 4'b0101) ? 24'h10_0000
            : (s[6] ? 24'h00_1000 : 24'h01_0000) << (s[4] ? 3 : s[3:2] - 1);
        return {1'b1, s[5] ? 24'h00_0000 : 24'h10_0000 - sz, s[5] ? sz - 24'h00_0001 : 24'h0f_ffff};
    endfunction
    task automatic check(input string n, input logic [63:0] s, x);
        checked++;
        if (s !== x) begin
            mismatches++;
            $display("Error %s expected %h seen %h", n, x, s);
        end
    endtask
    task automatic cmd(input logic [63:0] b, input int nb, n, input int q = 0);
        i_host.tx = {b << (64 - 8 * nb), 192'h0};
        i_host.run(n, q);
    endtask
    task automatic wren();
        cmd(8'h06, 1, 8);
        n0 = starts;
    endtask
    task automatic pulse();
        @(posedge clk) done <= 1;
        @(posedge clk) done <= 0;
        repeat (2) @(posedge clk);
    endtask
    task automatic conclude();
        $display("checked %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    always @(posedge clk) begin
        starts <= starts + ost;
        if (wv) wb <= {wb[7:0], wbyte};
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            mismatches++;
            conclude();
        end
    end
    initial begin
        repeat (3) @(posedge clk);
        rst <= 0;
        repeat (3) @(posedge clk);
        check("reset", {st, loe, pd, any}, 0);
        for (int i = 0; i < 32; i++) begin
            lf = nxt(lf);
            v = {lf[7], i[4:0], 2'b00};
            h = lf[15:8];
            wren();
            cmd({8'h01, v, h}, 3, 24);
            check("wrsr", {starts - n0, kd}, {32'd1, SFCD_CMD_WRSR});
            cmd(8'h04, 1, 8);
            cmd(8'h05, 1, 24);
            check("busy read", i_host.rx[15:0], {2{v & 8'hfc | 8'h03}});
            pulse();
            check("status", st, {6'h00, h[1:0], v & 8'hfc});
            check("prot", {any, any ? {lo, hi} : 48'h0}, prot_exp(v));
            cmd(8'h35, 1, 16);
            check("high", i_host.rx[7:0], {6'h00, h[1:0]});
        end
        wren();
        cmd(16'h0100, 2, 16);
        pulse();
        check("clear", st, 0);
        wren();
        cmd({8'h02, 4'h0, lf[19:0], lf[31:16]}, 6, 48);
        check("pp", {8'(starts - n0), kd, oa, wb}, {8'd1, SFCD_CMD_PP, 4'h0, lf[19:0], lf[31:16]});
        pulse();
        wren();
        cmd({8'h32, 4'h0, lf[19:0], lf[7:0]}, 5, 34, 224);
        check("qpp", {kd, wb[7:0]}, {SFCD_CMD_QPP, lf[7:0]});
        pulse();
        wren();
        cmd({8'h02, 32'h0}, 5, 39);
        check("partial", {starts - n0, st[1]}, {32'd0, 1'b1});
        for (int j = 0; j < 5; j++) begin
            wren();
            cmd({ops[j], 4'h0, lf[19:0]} >> (j > 2 ? 24 : 0), j > 2 ? 1 : 4, j > 2 ? 8 : 32);
            check("erase", {starts - n0, kd}, {32'd1, kinds[j]});
            pulse();
        end
        wren();
        cmd(16'h77aa, 2, 16);
        check("unknown", st[1], 1);
        cmd(8'h9f, 1, 40);
        check("jedec", i_host.rx[31:0], 32'h3c21_453c);
        for (int s = 0; s < 2; s++) begin
            cmd({8'h90, 23'h0, s[0]}, 4, 48);
            check("ident", i_host.rx[15:0], s ? 16'h7e3c : 16'h3c7e);
            cmd({8'hdf, 23'h0, s[0]}, 4, 18, 248);
            check("quad ident", i_host.rx[15:0], s ? 16'h7e3c : 16'h3c7e);
        end
        cmd(8'h04, 1, 8);
        cmd(8'hb9, 1, 8);
        wren();
        check("down", {pd, st[1]}, 2'b10);
        cmd(8'hab, 1, 48);
        check("wake", {i_host.rx[15:0], pd}, {16'h7e7e, 1'b0});
        conclude();
    end
endmodule
bind sfcd_decoder sfcd_properties i_props (.core_clk_in(core_clk_in), .rst_in(rst_in), .sel_n_in(sel_n_in),
    .op_done_in(op_done_in), .op_start_out(op_start_out), .wr_valid_out(wr_valid_out),
    .lanes_oe_out(lanes_oe_out), .status_out(status_out), .prot_lo_out(prot_lo_out),
    .prot_hi_out(prot_hi_out), .prot_any_out(prot_any_out));
